// >>> shared/warmup_defines.vh
// Constants for the oscillator warm-up counter
`ifndef WARMUP_DEFINES_VH
`define WARMUP_DEFINES_VH
`define SEL_WIDTH 2
`define DIV_WIDTH 2
`define SEL_RESET 2'h0
`define DIV_RESET 2'h3
`define SEL_INT_FAST 2'h0
`define SEL_EXT_FAST 2'h1
`define SEL_EXT_SLOW 2'h2
`define DIV_BY1 2'h0
`define DIV_BY2 2'h1
`define DIV_BY4 2'h2
`define DIV_BY8 2'h3
`define VALUE_RESET 8'h80
`define CNT_WIDTH 14
`define CMP_LSB 6
`define CMP_MSB 13
`define PRE_WIDTH 3
`endif

// >>> logic/warmup_divider.v
// Source clock selector and three-stage binary divider
`timescale 1ns/1ps
`include "warmup_defines.vh"
module warmup_divider #(
  parameter STAGES = `PRE_WIDTH
) (
  input wire clk,
  input wire rst,
  input wire clear,
  input wire run,
  input wire [`SEL_WIDTH-1:0] source,
  input wire [`DIV_WIDTH-1:0] ratio,
  input wire intFastTick,
  input wire extFastTick,
  input wire extSlowTick,
  output reg countTick
);
  reg [STAGES-1:0] stage;
  reg srcTick;
  reg next_countTick;
  wire [STAGES-1:0] stageNext;
  // ****************************************
  // Source selection
  // ****************************************
  always @* begin
    case (source)
      `SEL_INT_FAST: srcTick = intFastTick;
      `SEL_EXT_FAST: srcTick = extFastTick;
      `SEL_EXT_SLOW: srcTick = extSlowTick;
      default: srcTick = 1'b0;
    endcase
  end
  // ****************************************
  // Divider stages and ratio tap
  // ****************************************
  assign stageNext = stage + {{(STAGES-1){1'b0}}, 1'b1};
  always @* begin
    next_countTick = 1'b0;
    if (run && srcTick) begin
      case (ratio)
        `DIV_BY1: next_countTick = 1'b1;
        `DIV_BY2: next_countTick = (stageNext[0] == 1'b0);
        `DIV_BY4: next_countTick = (stageNext[1:0] == 2'h0);
        `DIV_BY8: next_countTick = (stageNext[2:0] == 3'h0);
        default: next_countTick = 1'b0;
      endcase
    end
  end
  // RQ1 divider stages
  // RQ10 ratio select
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stage <= {STAGES{1'b0}};
      countTick <= 1'b0;
    end else begin
      countTick <= next_countTick;
      if (clear)
        stage <= {STAGES{1'b0}};
      else if (run && srcTick)
        stage <= stageNext;
    end
  end
endmodule // warmup_divider

// >>> logic/oscillator_warmup_counter.v
// Oscillator warm-up counter: reset, STOP release and software warm-up timing
// Contract
// RQ1: Timer is source selector, three-stage divider and fourteen-stage counter.
// RQ2: After power-on release only the timer runs; core and peripherals stay reset.
// RQ3: Reset sets source select to 0 and division to binary 11.
// RQ4: Reset warm-up counts internal fast clock regardless of source select.
// RQ5: Reset warm-up ends at upper-byte match, releasing core and peripherals.
// RQ6: Warm-up value register holds 128 after reset.
// RQ7: STOP release counts the clock that ran the system at STOP entry.
// RQ8: STOP warm-up ends at upper-byte match and execution resumes.
// RQ9: Software programs division and value before entering STOP.
// RQ10: Division 00,01,10,11 gives divide by 1,2,4,8.
// RQ11: Warm-up lasts value times 64 divided periods, value 1 to 255.
// RQ12: Software warm-up source: 00 internal fast, 01 external fast, 10 slow.
// RQ13: Setting an oscillator enable bit starts oscillator and warm-up count.
// RQ14: Software warm-up match raises done interrupt, stops and clears counter.
// RQ15: Abort stops and clears counter, then abort bit clears itself.
// RQ16: Abort leaves enable bits; software clears enable to restart.
// RQ17: Only a 0-to-1 enable transition starts counting.
// RQ18: STOP during software warm-up freezes count, resumes after release.
// RQ19: Software must not enter STOP during a software warm-up.
// RQ20: Compare counter bits 13 to 6 with the eight-bit value register.
`timescale 1ns/1ps
`include "warmup_defines.vh"
module oscillator_warmup_counter #(
  parameter CNT_BITS = `CNT_WIDTH
) (
  input wire clk,
  input wire rst,
  input wire intFastTick,
  input wire extFastTick,
  input wire extSlowTick,
  input wire ctrlWrite,
  input wire [`SEL_WIDTH-1:0] writeSource,
  input wire [`DIV_WIDTH-1:0] writeRatio,
  input wire writeAbort,
  input wire valueWrite,
  input wire [7:0] writeValue,
  input wire intFastEnableWrite,
  input wire intFastEnableData,
  input wire extFastEnableWrite,
  input wire extFastEnableData,
  input wire extSlowEnableWrite,
  input wire extSlowEnableData,
  input wire stopEnter,
  input wire stopRelease,
  input wire [`SEL_WIDTH-1:0] stopClockSource,
  output reg [`SEL_WIDTH-1:0] warmupSource,
  output reg [`DIV_WIDTH-1:0] warmupRatio,
  output reg warmupAbort,
  output reg [7:0] warmupValue,
  output reg intFastEnable,
  output reg extFastEnable,
  output reg extSlowEnable,
  output reg coreReset,
  output reg stopWarmup,
  output reg softWarmup,
  output reg frozen,
  output reg resumeCpu,
  output reg warmupDoneIrq,
  output reg [CNT_BITS-1:0] count
);
  localparam ST_RESET = 2'h0;
  localparam ST_IDLE = 2'h1;
  localparam ST_STOPPED = 2'h2;
  localparam ST_STOPWARM = 2'h3;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [`SEL_WIDTH-1:0] activeSource;
  reg [`SEL_WIDTH-1:0] stopSource;
  reg running;
  wire countTick;
  wire match;
  wire anyRise;
  wire abortNow;
  wire clearDiv;
  wire inReset;
  wire inIdle;
  wire inStopped;
  wire inStopWarm;
  wire resetDone;
  wire idleStop;
  wire idleAbort;
  wire softDone;
  wire softStart;
  wire stopWake;
  wire stopDone;

  // ****************************************
  // Helpers
  // ****************************************
  function rise;
    input oldBit;
    input wr;
    input dat;
    begin
      rise = wr && dat && !oldBit;
    end
  endfunction

  // RQ20 upper byte compare
  assign match = (count[`CMP_MSB:`CMP_LSB] == warmupValue);
  // RQ17 rising enable only
  assign anyRise = rise(intFastEnable, intFastEnableWrite, intFastEnableData)
    || rise(extFastEnable, extFastEnableWrite, extFastEnableData)
    || rise(extSlowEnable, extSlowEnableWrite, extSlowEnableData);
  assign abortNow = ctrlWrite && writeAbort;
  // Divider restarts from zero at every warm-up start, end or abort
  assign clearDiv = abortNow || (running && match) || anyRise || stopWake;

  // ****************************************
  // Mode events
  // ****************************************
  assign inReset = (state == ST_RESET);
  assign inIdle = (state == ST_IDLE);
  assign inStopped = (state == ST_STOPPED);
  assign inStopWarm = (state == ST_STOPWARM);
  assign resetDone = inReset && match;
  // STOP entry beats abort, abort beats done, done beats start
  assign idleStop = inIdle && stopEnter;
  assign idleAbort = inIdle && !stopEnter && abortNow;
  assign softDone = inIdle && !stopEnter && !abortNow && softWarmup && match;
  assign softStart = inIdle && !stopEnter && !abortNow && !(softWarmup && match) && anyRise;
  assign stopWake = inStopped && stopRelease;
  assign stopDone = inStopWarm && running && match;

  // ****************************************
  // Source routing
  // ****************************************
  always @* begin
    activeSource = warmupSource;
    case (state)
      // RQ4 reset counts fast internal
      ST_RESET: activeSource = `SEL_INT_FAST;
      // RQ7 STOP entry clock
      ST_STOPWARM: activeSource = stopSource;
      // RQ12 software source select
      default: activeSource = warmupSource;
    endcase
  end

  warmup_divider #(
    .STAGES(`PRE_WIDTH)
  ) divider (
    .clk(clk),
    .rst(rst),
    .clear(clearDiv),
    .run(running),
    .source(activeSource),
    .ratio(warmupRatio),
    .intFastTick(intFastTick),
    .extFastTick(extFastTick),
    .extSlowTick(extSlowTick),
    .countTick(countTick)
  );

  // ****************************************
  // Configuration fields
  // ****************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      // RQ3 reset field values
      warmupSource <= `SEL_RESET;
      warmupRatio <= `DIV_RESET;
    end else if (ctrlWrite) begin
      warmupSource <= writeSource;
      warmupRatio <= writeRatio;
    end
  end

  // RQ15 abort self clears
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      warmupAbort <= 1'b0;
    end else begin
      warmupAbort <= abortNow;
    end
  end

  // RQ6 value of 128
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      warmupValue <= `VALUE_RESET;
    end else if (valueWrite) begin
      warmupValue <= writeValue;
    end
  end

  // ****************************************
  // Oscillator enable bits
  // ****************************************
  // RQ16 abort keeps enables
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      intFastEnable <= 1'b1;
    end else if (intFastEnableWrite) begin
      intFastEnable <= intFastEnableData;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      extFastEnable <= 1'b0;
    end else if (extFastEnableWrite) begin
      extFastEnable <= extFastEnableData;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      extSlowEnable <= 1'b0;
    end else if (extSlowEnableWrite) begin
      extSlowEnable <= extSlowEnableData;
    end
  end

  // ****************************************
  // Mode sequencing
  // ****************************************
  always @* begin
    next_state = state;
    case (state)
      ST_RESET: begin
        if (match)
          next_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (stopEnter)
          next_state = ST_STOPPED;
      end
      ST_STOPPED: begin
        if (stopRelease)
          next_state = ST_STOPWARM;
      end
      ST_STOPWARM: begin
        if (running && match)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // RQ7 capture STOP entry clock
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stopSource <= `SEL_INT_FAST;
    end else if (idleStop) begin
      stopSource <= stopClockSource;
    end
  end

  // ****************************************
  // Reset release and run control
  // ****************************************
  // RQ2 core held in reset
  // RQ5 release core on match
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      coreReset <= 1'b1;
    end else if (resetDone) begin
      coreReset <= 1'b0;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      running <= 1'b1;
    end else if (resetDone || idleStop || idleAbort || softDone || stopDone) begin
      running <= 1'b0;
    end else if (softStart || stopWake) begin
      running <= 1'b1;
    end
  end

  // RQ13 software start
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      softWarmup <= 1'b0;
    end else if (idleAbort || softDone || stopDone) begin
      softWarmup <= 1'b0;
    end else if (softStart) begin
      softWarmup <= 1'b1;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stopWarmup <= 1'b0;
    end else if (stopWake) begin
      stopWarmup <= 1'b1;
    end else if (stopDone) begin
      stopWarmup <= 1'b0;
    end
  end

  // RQ18 freeze soft count
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      frozen <= 1'b0;
    end else if (idleStop) begin
      frozen <= softWarmup;
    end else if (stopDone) begin
      frozen <= 1'b0;
    end
  end

  // ****************************************
  // Completion pulses
  // ****************************************
  // RQ8 resume after match
  // RQ14 done interrupt
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      resumeCpu <= 1'b0;
      warmupDoneIrq <= 1'b0;
    end else begin
      resumeCpu <= stopDone;
      warmupDoneIrq <= softDone;
    end
  end

  // ****************************************
  // Fourteen-stage counter
  // ****************************************
  // RQ14 clear at match
  // RQ18 resume from held value
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= {CNT_BITS{1'b0}};
    end else if (idleAbort || softDone || softStart || stopDone || (stopWake && !frozen)) begin
      count <= {CNT_BITS{1'b0}};
    end else if (countTick && running) begin
      count <= count + {{(CNT_BITS-1){1'b0}}, 1'b1};
    end
  end
endmodule // oscillator_warmup_counter

// >>> testbench/warmup_counter_chk.sv
// Port checker for the oscillator warm-up counter
`timescale 1ns/1ps
`include "warmup_defines.vh"
module warmup_counter_chk #(
  parameter CNT_BITS = `CNT_WIDTH
) (
  input wire clk,
  input wire rst,
  input wire ctrlWrite,
  input wire writeAbort,
  input wire [`SEL_WIDTH-1:0] writeSource,
  input wire [`DIV_WIDTH-1:0] writeRatio,
  input wire valueWrite,
  input wire [7:0] writeValue,
  input wire extFastEnableWrite,
  input wire extFastEnableData,
  input wire extFastEnable,
  input wire [`SEL_WIDTH-1:0] warmupSource,
  input wire [`DIV_WIDTH-1:0] warmupRatio,
  input wire warmupAbort,
  input wire [7:0] warmupValue,
  input wire coreReset,
  input wire softWarmup,
  input wire resumeCpu,
  input wire warmupDoneIrq,
  input wire [CNT_BITS-1:0] count
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence abortReq;
    ctrlWrite && writeAbort && !coreReset;
  endsequence
  sequence abortDone;
    warmupAbort && count == 0 && !softWarmup ##1 !warmupAbort;
  endsequence
  abort_clears_a: assert property (abortReq |=> abortDone) else $error("abort did not clear");
  abort_keeps_a: assert property (abortReq and !extFastEnableWrite |=> $stable(extFastEnable))
    else $error("abort changed enable");
  cfg_write_a: assert property (ctrlWrite && !coreReset |=>
    warmupSource == $past(writeSource) && warmupRatio == $past(writeRatio)) else $error("config not written");
  value_write_a: assert property (valueWrite && !coreReset |=> warmupValue == $past(writeValue))
    else $error("value not written");
  soft_start_a: assert property (extFastEnableWrite && extFastEnableData && !extFastEnable && !ctrlWrite
    && !softWarmup && !coreReset |=> softWarmup && count == 0) else $error("warm-up did not start");
  no_restart_a: assert property (extFastEnableWrite && extFastEnable && !softWarmup && !ctrlWrite
    |=> !softWarmup) else $error("warm-up restarted");
  done_end_a: assert property (warmupDoneIrq |-> !softWarmup && count == 0 ##1 !warmupDoneIrq)
    else $error("done pulse wrong");
  core_hold_a: assert property (coreReset && count[`CMP_MSB:`CMP_LSB] != warmupValue |=> coreReset)
    else $error("core released early");
  core_fall_a: assert property ($fell(coreReset) |-> $past(count[`CMP_MSB:`CMP_LSB]) == warmupValue)
    else $error("core released off match");
  resume_pulse_a: assert property (resumeCpu |=> !resumeCpu) else $error("resume not a pulse");
endmodule // warmup_counter_chk
bind oscillator_warmup_counter warmup_counter_chk #(.CNT_BITS(CNT_BITS)) chk_i (.*);

// >>> testbench/tb_top.sv
// Self-checking bench for the oscillator warm-up counter
`timescale 1ns/1ps
module tb_top;
  reg clk = 1'b0, rst = 1'b1, intFastTick = 1'b0, extFastTick = 1'b0, extSlowTick = 1'b0;
  reg ctrlWrite = 1'b0, writeAbort = 1'b0, valueWrite = 1'b0, stopEnter = 1'b0, stopRelease = 1'b0;
  reg intFastEnableWrite = 1'b0, extFastEnableWrite = 1'b0, extSlowEnableWrite = 1'b0;
  reg intFastEnableData = 1'b0, extFastEnableData = 1'b0, extSlowEnableData = 1'b0;
  reg [1:0] writeSource = 2'h0, writeRatio = 2'h0, stopClockSource = 2'h0;
  reg [7:0] writeValue = 8'h00;
  wire [1:0] warmupSource, warmupRatio;
  wire [7:0] warmupValue;
  wire [13:0] count;
  wire warmupAbort, intFastEnable, extFastEnable, extSlowEnable, coreReset;
  wire stopWarmup, softWarmup, frozen, resumeCpu, warmupDoneIrq;
  integer n_fail = 0, n_checks = 0, seed = 61932, cyc = 0, t0 = 0, s, d, v, k, m;
  integer expQ[$];
  reg prevCore = 1'b1;
  oscillator_warmup_counter dut (.*);
  always #10 clk = ~clk;
  // ****************
  // Tasks
  // ****************
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
    end
  endtask
  task complete_run;
    begin
      if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task cfg(input [1:0] src, input [1:0] div, input ab, input [7:0] val);
    begin
      @(negedge clk) {ctrlWrite, valueWrite, writeSource, writeRatio, writeAbort, writeValue} = {2'h3, src, div, ab, val};
      @(negedge clk) {ctrlWrite, valueWrite, writeAbort} = 3'h0;
    end
  endtask
  task en(input integer i, input b);
    begin
      @(negedge clk) {extSlowEnableWrite, extFastEnableWrite, intFastEnableWrite} = 3'h1 << i;
      {extSlowEnableData, extFastEnableData, intFastEnableData} = {3{b}};
      @(negedge clk) {extSlowEnableWrite, extFastEnableWrite, intFastEnableWrite} = 3'h0;
    end
  endtask
  task wq;
    begin
      k = 0;
      while (expQ.size() > 0 && k < 70000) begin
        @(posedge clk) k = k + 1;
      end
      chk(expQ.size(), 0);
    end
  endtask
  // Ticks: internal fast every cycle, external fast every 2, slow every 4
  always @(negedge clk) begin
    intFastTick <= 1'b1;
    extFastTick <= cyc[0];
    extSlowTick <= cyc[1:0] == 2'h0;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end
  // Results end a warm-up; the oldest noted duration is compared
  always @(posedge clk) begin
    prevCore <= coreReset;
    if (warmupDoneIrq === 1'b1 || resumeCpu === 1'b1 || (prevCore === 1'b1 && coreReset === 1'b0)) begin
      m = expQ.size() > 0 ? expQ.pop_front() : 0;
      chk((cyc - t0 >= m) && (cyc - t0 <= m + 8), 1);
    end
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t0 = cyc;
    chk({warmupSource, warmupRatio, warmupValue, coreReset}, {2'h0, 2'h3, 8'h80, 1'b1});
    expQ.push_back(65536);
    wq;
    for (s = 0; s < 3; s = s + 1)
      for (d = 0; d < 4; d = d + 1) begin
        v = $unsigned($random(seed)) % 3 + 1;
        cfg(s, d, 1'b0, v);
        en(s, 1'b0);
        expQ.push_back(v * 64 * (1 << d) * (1 << s));
        t0 = cyc;
        en(s, 1'b1);
        wq;
      end
    en(1, 1'b1);
    repeat (3) @(negedge clk);
    chk({softWarmup, extFastEnable, extSlowEnable}, {1'b0, 1'b1, 1'b1});
    cfg(2'h0, 2'h3, 1'b0, 8'hC8);
    en(0, 1'b0);
    en(0, 1'b1);
    repeat (20) @(negedge clk);
    cfg(2'h0, 2'h3, 1'b1, 8'hC8);
    chk({softWarmup, count, intFastEnable, warmupAbort}, {1'b0, 14'h0, 1'b1, 1'b1});
    cfg(2'h0, 2'h1, 1'b0, 8'h02);
    @(negedge clk) {stopEnter, stopClockSource} = 3'h5;
    @(negedge clk) stopEnter = 1'b0;
    repeat (5) @(negedge clk);
    expQ.push_back(512);
    t0 = cyc;
    stopRelease = 1'b1;
    @(negedge clk) stopRelease = 1'b0;
    chk({stopWarmup, frozen}, {1'b1, 1'b0});
    wq;
    complete_run;
  end
endmodule // tb_top
